// File: shared/rtca_pkg.sv
/*
 * Package of the alarm compare register block: register addresses,
 * writable bit masks, reset values and the packed carriers.
 * Assumes a 4-bit register address from the serial front end.
 */
package rtca_pkg;

    // Register addresses on the internal register port
    localparam logic [3:0] RTCA_ADDR_WK_MIN = 4'h8;
    localparam logic [3:0] RTCA_ADDR_WK_HOUR = 4'h9;
    localparam logic [3:0] RTCA_ADDR_WK_DOW = 4'hA;
    localparam logic [3:0] RTCA_ADDR_DY_MIN = 4'hB;
    localparam logic [3:0] RTCA_ADDR_DY_HOUR = 4'hC;

    // Writable bits; all others read as zero
    localparam logic [7:0] RTCA_MASK_MIN = 8'h7F;
    localparam logic [7:0] RTCA_MASK_HOUR = 8'h3F;
    localparam logic [7:0] RTCA_MASK_DOW = 8'h7F;

    // Field layout
    localparam int RTCA_DAYS = 7;
    localparam int RTCA_PM_POS = 5;

    // Value after reset (content is undefined by nature, zero chosen)
    localparam logic [7:0] RTCA_RST_VAL = 8'h00;
    localparam logic [4:0] RTCA_RST_WRITTEN = 5'h00;
    localparam logic [4:0] RTCA_ALL_WRITTEN = 5'h1F;

    // Written-register bookkeeping positions
    localparam int RTCA_W_WK_MIN = 0;
    localparam int RTCA_W_WK_HOUR = 1;
    localparam int RTCA_W_WK_DOW = 2;
    localparam int RTCA_W_DY_MIN = 3;
    localparam int RTCA_W_DY_HOUR = 4;

    // Current time from the time and calendar counters
    typedef struct packed {
        logic [2:0] dow_counter;
        logic [5:0] hour;
        logic [6:0] minute;
    } rtca_time_t;

    // One access on the register port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] data;
    } rtca_access_t;

    // Stored alarm times
    typedef struct packed {
        logic [6:0] weekday_sel;
        logic [5:0] weekly_hour;
        logic [6:0] weekly_minute;
        logic [5:0] daily_hour;
        logic [6:0] daily_minute;
    } rtca_alarm_t;

    // Whole state of the register block
    typedef struct packed {
        rtca_alarm_t alarm;
        logic [4:0] written;
        logic mode_24h_seen;
        logic weekly_mode_stale;
        logic daily_mode_stale;
        logic [7:0] rdata;
        logic weekly_match;
        logic daily_match;
        logic weekly_event;
        logic daily_event;
        logic weekly_valid;
        logic daily_valid;
        logic weekly_pm;
        logic daily_pm;
    } rtca_state_t;

endpackage : rtca_pkg

// File: core/rtca_dow_select.sv
/*
 * Weekday select of the weekly alarm: picks the select bit that
 * belongs to the current day-of-week counter value.
 * Assumes the counter is stable for the cycle it is sampled in.
 */
`timescale 1ns/1ps
module rtca_dow_select
    import rtca_pkg::*;
(
    // Stored select bits and counter
    input wire logic [6:0] weekday_sel,
    input wire logic [2:0] dow_counter,
    // Result
    output logic day_hit
);

    logic [RTCA_DAYS-1:0] per_day;

    // One term per weekday; counter 111 owns no bit and never hits
    genvar gi;
    generate
        for (gi = 0; gi < RTCA_DAYS; gi++) begin : g_day
            assign per_day[gi] = weekday_sel[gi] && (dow_counter == 3'(gi));
        end
    endgenerate

    // All-zero select gives no hit at all
    assign day_hit = |per_day;

endmodule : rtca_dow_select

// File: core/rtca_time_cmp.sv
/*
 * Hour and minute equality of one alarm against the time counters.
 * Assumes both sides use the same 12/24-hour encoding.
 */
`timescale 1ns/1ps
module rtca_time_cmp
    import rtca_pkg::*;
(
    // Stored alarm time
    input wire logic [5:0] alarm_hour,
    input wire logic [6:0] alarm_minute,
    // Current time
    input wire logic [5:0] cur_hour,
    input wire logic [6:0] cur_minute,
    // Result
    output logic time_hit
);

    // Raw BCD compare: bit 5 is PM or tens-20 alike on both sides
    assign time_hit = (alarm_hour == cur_hour) && (alarm_minute == cur_minute);

endmodule : rtca_time_cmp

// File: core/rtca_alarm_regs.sv
/*
 * Weekly and daily alarm setting registers with their compare logic.
 * Holds weekly minute, hour and weekday select, daily minute and hour,
 * reachable on the internal register port behind the serial interface.
 *
 * Register map on the port; bits outside each field read zero:
 *   8h  weekly minute, bits 6..0, BCD
 *   9h  weekly hour, bits 5..0, BCD, bit 5 is PM or tens-20
 *   Ah  weekday select, bits 6..0, one bit per day counter value
 *   Bh  daily minute, bits 6..0, BCD
 *   Ch  daily hour, bits 5..0, BCD, bit 5 is PM or tens-20
 *   Other addresses read 00h and drop writes.
 *
 * 12-hour codes of an alarm hour: 12h is midnight, 01h..11h the
 * morning, 32h is noon and 21h..31h the afternoon; bit 5 flags PM.
 *
 * Timing: a write lands on the edge that samples its strobe; a read
 * returns its byte on that same edge and holds it until the next read.
 * A read and a write to one address in one cycle return the old byte.
 * Matches are registered levels, one edge behind the counters; each
 * event output pulses for one cycle on a rise of its match.
 *
 * Status: valid says that every register of an alarm was written
 * since reset or the last oscillator stop; stale says that the
 * 12/24-hour mode moved since that alarm's hour was last written;
 * pm shows hour bit 5 while in 12-hour mode.
 *
 * Limitations: matches are not gated by valid or stale, so software
 * must check both before it trusts an alarm; stored values survive an
 * oscillator stop but are then meaningless, and are zero after reset.
 * Counter value 7 owns no select bit and never gives a weekly match.
 *
 * Assumes the front end presents one-cycle write and read strobes and
 * that the time counters and 12/24-hour mode come from the core.
 */
// Contract
// - The weekday select register keeps seven bits 6..0; bit 7 is dropped and reads zero.
// - Select bit n belongs to day-of-week counter value n, for values 000 to 110.
// - With all seven select bits clear the weekly alarm never matches.
// - Weekly hour bit 5 is the PM flag in 12-hour mode and the tens-20 bit in 24-hour mode.
// - Daily hour bit 5 is the PM flag in 12-hour mode and the tens-20 bit in 24-hour mode.
// - In 12-hour mode midnight is coded 12 and noon 32 in an alarm hour.
// - The daily minute register keeps a seven-bit BCD minute; bit 7 is dropped and reads zero.
// - The daily hour register keeps six bits 5..0; bits 7 and 6 are dropped and read zero.
// - After an oscillator stop the value bits are undefined; reserved bits still read zero.
// - The weekly minute register keeps a seven-bit BCD minute; bit 7 reads zero.
// - The weekly hour register keeps six bits 5..0; bits 7 and 6 read zero.
`timescale 1ns/1ps
module rtca_alarm_regs
    import rtca_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port from the serial front end
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Time and calendar counters
    input wire logic [2:0] dow_counter,
    input wire logic [5:0] cur_hour,
    input wire logic [6:0] cur_minute,
    input wire logic mode_24h,
    // Oscillation stop indication
    input wire logic osc_stop_flag,
    // Compare results
    output logic weekly_match,
    output logic daily_match,
    output logic weekly_event,
    output logic daily_event,
    // Status of the stored settings
    output logic weekly_valid,
    output logic daily_valid,
    output logic weekly_mode_stale,
    output logic daily_mode_stale,
    output logic weekly_pm,
    output logic daily_pm
);

    rtca_state_t state;
    rtca_state_t next_state;
    rtca_access_t acc;
    rtca_time_t now;
    logic weekly_day_hit;
    logic weekly_time_hit;
    logic daily_time_hit;

    // Bundle the port inputs
    assign acc = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, data: reg_wdata};
    assign now = '{dow_counter: dow_counter, hour: cur_hour, minute: cur_minute};

    // Weekday part of the weekly alarm
    rtca_dow_select u_dow_select (
        .weekday_sel(state.alarm.weekday_sel),
        .dow_counter(now.dow_counter),
        .day_hit(weekly_day_hit)
    );

    // Hour and minute part of the weekly alarm
    rtca_time_cmp u_weekly_cmp (
        .alarm_hour(state.alarm.weekly_hour),
        .alarm_minute(state.alarm.weekly_minute),
        .cur_hour(now.hour),
        .cur_minute(now.minute),
        .time_hit(weekly_time_hit)
    );

    // Hour and minute of the daily alarm
    rtca_time_cmp u_daily_cmp (
        .alarm_hour(state.alarm.daily_hour),
        .alarm_minute(state.alarm.daily_minute),
        .cur_hour(now.hour),
        .cur_minute(now.minute),
        .time_hit(daily_time_hit)
    );

    // Next-state logic
    always_comb begin
        next_state = state;

        // Register writes; unused and reserved bits are masked off
        if (acc.wr) begin
            case (acc.addr)
                RTCA_ADDR_WK_MIN: begin
                    next_state.alarm.weekly_minute = 7'(acc.data & RTCA_MASK_MIN);
                    next_state.written[RTCA_W_WK_MIN] = 1'b1;
                end
                RTCA_ADDR_WK_HOUR: begin
                    next_state.alarm.weekly_hour = 6'(acc.data & RTCA_MASK_HOUR);
                    next_state.written[RTCA_W_WK_HOUR] = 1'b1;
                end
                RTCA_ADDR_WK_DOW: begin
                    next_state.alarm.weekday_sel = 7'(acc.data & RTCA_MASK_DOW);
                    next_state.written[RTCA_W_WK_DOW] = 1'b1;
                end
                RTCA_ADDR_DY_MIN: begin
                    next_state.alarm.daily_minute = 7'(acc.data & RTCA_MASK_MIN);
                    next_state.written[RTCA_W_DY_MIN] = 1'b1;
                end
                RTCA_ADDR_DY_HOUR: begin
                    next_state.alarm.daily_hour = 6'(acc.data & RTCA_MASK_HOUR);
                    next_state.written[RTCA_W_DY_HOUR] = 1'b1;
                end
                default: begin
                    next_state.written = state.written;
                end
            endcase
        end

        // Oscillator stop voids the settings; a write in the same cycle
        // still counts, but each cycle with the flag up clears every earlier mark
        if (osc_stop_flag) begin
            next_state.written = RTCA_RST_WRITTEN;
            if (acc.wr) begin
                case (acc.addr)
                    RTCA_ADDR_WK_MIN: next_state.written[RTCA_W_WK_MIN] = 1'b1;
                    RTCA_ADDR_WK_HOUR: next_state.written[RTCA_W_WK_HOUR] = 1'b1;
                    RTCA_ADDR_WK_DOW: next_state.written[RTCA_W_WK_DOW] = 1'b1;
                    RTCA_ADDR_DY_MIN: next_state.written[RTCA_W_DY_MIN] = 1'b1;
                    RTCA_ADDR_DY_HOUR: next_state.written[RTCA_W_DY_HOUR] = 1'b1;
                    default: next_state.written = RTCA_RST_WRITTEN;
                endcase
            end
        end

        // Register reads; bits above each field come back as zero
        if (acc.rd) begin
            case (acc.addr)
                RTCA_ADDR_WK_MIN: next_state.rdata = {1'b0, state.alarm.weekly_minute};
                RTCA_ADDR_WK_HOUR: next_state.rdata = {2'b00, state.alarm.weekly_hour};
                RTCA_ADDR_WK_DOW: next_state.rdata = {1'b0, state.alarm.weekday_sel};
                RTCA_ADDR_DY_MIN: next_state.rdata = {1'b0, state.alarm.daily_minute};
                RTCA_ADDR_DY_HOUR: next_state.rdata = {2'b00, state.alarm.daily_hour};
                default: next_state.rdata = RTCA_RST_VAL;
            endcase
        end

        // A mode change makes stored hours stale until rewritten; the
        // stale set wins over a hour write in the same cycle
        next_state.mode_24h_seen = mode_24h;
        if (acc.wr && acc.addr == RTCA_ADDR_WK_HOUR) begin
            next_state.weekly_mode_stale = 1'b0;
        end
        if (acc.wr && acc.addr == RTCA_ADDR_DY_HOUR) begin
            next_state.daily_mode_stale = 1'b0;
        end
        if (mode_24h != state.mode_24h_seen) begin
            next_state.weekly_mode_stale = 1'b1;
            next_state.daily_mode_stale = 1'b1;
        end

        // Bit 5 is PM only in 12-hour mode, tens-20 otherwise
        next_state.weekly_pm = !mode_24h && next_state.alarm.weekly_hour[RTCA_PM_POS];
        next_state.daily_pm = !mode_24h && next_state.alarm.daily_hour[RTCA_PM_POS];

        // Whole alarm considered loaded once each of its registers is
        next_state.weekly_valid = &next_state.written[RTCA_W_WK_DOW:RTCA_W_WK_MIN];
        next_state.daily_valid = &next_state.written[RTCA_W_DY_HOUR:RTCA_W_DY_MIN];

        // Compare against the counters; host keeps values legal, so
        // a non-existent setting merely never matches
        next_state.weekly_match = weekly_day_hit && weekly_time_hit;
        next_state.daily_match = daily_time_hit;

        // One pulse on each rise of a match
        next_state.weekly_event = next_state.weekly_match && !state.weekly_match;
        next_state.daily_event = next_state.daily_match && !state.daily_match;
    end

    // State register; synchronous reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state flops
    assign reg_rdata = state.rdata;
    assign weekly_match = state.weekly_match;
    assign daily_match = state.daily_match;
    assign weekly_event = state.weekly_event;
    assign daily_event = state.daily_event;
    assign weekly_valid = state.weekly_valid;
    assign daily_valid = state.daily_valid;
    assign weekly_mode_stale = state.weekly_mode_stale;
    assign daily_mode_stale = state.daily_mode_stale;
    assign weekly_pm = state.weekly_pm;
    assign daily_pm = state.daily_pm;

endmodule : rtca_alarm_regs

// File: testbench/rtca_alarm_regs_props.sv
/* Checker of the alarm register block, bound to its ports.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module rtca_alarm_regs_props
    import rtca_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Counters and results
    input wire logic [2:0] dow_counter,
    input wire logic [5:0] cur_hour,
    input wire logic [6:0] cur_minute,
    input wire logic mode_24h,
    input wire logic weekly_match,
    input wire logic daily_match,
    input wire logic weekly_event,
    input wire logic daily_event,
    input wire logic weekly_pm,
    input wire logic daily_pm
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Write of the weekday select, then its read-back
    sequence s_dow_wr;
        reg_wr && reg_addr == RTCA_ADDR_WK_DOW;
    endsequence
    sequence s_dow_rd;
        reg_rd && !reg_wr && reg_addr == RTCA_ADDR_WK_DOW;
    endsequence
    chk_dow_readback: assert property (
        s_dow_wr ##1 s_dow_rd |=> reg_rdata == ($past(reg_wdata, 2) & RTCA_MASK_DOW))
        else $error("weekday select read back wrong");
    chk_msb_zero: assert property (
        reg_rd |=> !reg_rdata[7]) else $error("read data bit 7 set");
    chk_hour_top: assert property (
        reg_rd && (reg_addr == RTCA_ADDR_DY_HOUR || reg_addr == RTCA_ADDR_WK_HOUR)
        |=> reg_rdata[7:6] == 2'b00) else $error("hour bits 7:6 read set");
    chk_dow_seven: assert property (
        dow_counter == 3'h7 |=> !weekly_match) else $error("weekly match on day seven");
    // Time moved away from a matching setting, no write in between
    chk_daily_follow: assert property (
        daily_match && !reg_wr && !$past(reg_wr)
        && {cur_hour, cur_minute} != $past({cur_hour, cur_minute}) |=> !daily_match)
        else $error("daily match held after time moved");
    chk_event_rise: assert property (
        daily_event == $rose(daily_match) && weekly_event == $rose(weekly_match))
        else $error("event pulse not on match rise");
    chk_pm_24h: assert property (
        mode_24h |=> !weekly_pm && !daily_pm) else $error("pm flag in 24-hour mode");
    chk_pm_readback: assert property (
        reg_rd && !reg_wr && !mode_24h && reg_addr == RTCA_ADDR_DY_HOUR
        |=> reg_rdata[RTCA_PM_POS] == daily_pm) else $error("pm flag differs from bit 5");
endmodule : rtca_alarm_regs_props

bind rtca_alarm_regs rtca_alarm_regs_props chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .dow_counter(dow_counter), .cur_hour(cur_hour), .cur_minute(cur_minute),
    .mode_24h(mode_24h), .weekly_match(weekly_match), .daily_match(daily_match),
    .weekly_event(weekly_event), .daily_event(daily_event),
    .weekly_pm(weekly_pm), .daily_pm(daily_pm)
);

// File: testbench/rtca_host_model.sv
/* Host side of the register port: one-byte reads and writes.
   Assumes callers enter its tasks just after a rising edge. */
`timescale 1ns/1ps
module rtca_host_model
    import rtca_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Register port towards the block
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [3:0] reg_addr = 4'h0,
    output logic [7:0] reg_wdata = 8'h00
);
    // One strobe, still driven after its sampling edge until release_port or the next access
    task automatic access(input logic w, input logic r, input logic [3:0] a,
                          input logic [7:0] d);
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1;
    endtask : access
    // Idle port drops both strobes and inverts address and data, so stale bytes never look valid
    task automatic release_port();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask : release_port
endmodule : rtca_host_model

// File: testbench/rtca_alarm_regs_tb.sv
/* Bench of the alarm registers: host model on the register port,
   counters driven here, read data checked against a queue of notes.
   Assumes read data settles after the edge that samples the read. */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module rtca_alarm_regs_tb
    import rtca_pkg::*;
    ;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd, rd_pend = 1'b0;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [2:0] dow_counter = 3'h7;
    logic [5:0] cur_hour = 6'h00;
    logic [6:0] cur_minute = 7'h00;
    logic mode_24h = 1'b1;
    logic osc_stop_flag = 1'b0;
    logic weekly_match, daily_match, weekly_event, daily_event;
    logic weekly_valid, daily_valid, weekly_pm, daily_pm;
    logic weekly_mode_stale, daily_mode_stale;
    logic [7:0] exp_v;
    logic [31:0] lfsr = 32'h6EDE2EC2;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    rtca_host_model host_u (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    rtca_alarm_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .dow_counter(dow_counter), .cur_hour(cur_hour), .cur_minute(cur_minute),
        .mode_24h(mode_24h), .osc_stop_flag(osc_stop_flag), .weekly_match(weekly_match),
        .daily_match(daily_match), .weekly_event(weekly_event), .daily_event(daily_event),
        .weekly_valid(weekly_valid), .daily_valid(daily_valid),
        .weekly_mode_stale(weekly_mode_stale), .daily_mode_stale(daily_mode_stale),
        .weekly_pm(weekly_pm), .daily_pm(daily_pm));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    // Run is about 160 cycles; a hang is cut well beyond that
    always @(posedge core_clk) begin
        rd_pend <= reg_rd && rst_n;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end
    // Oldest note against the data of each finished read
    always @(negedge core_clk) begin
        if (rd_pend) begin
            // Pop once; the macro reads its expected value twice
            exp_v = exp_q.pop_front();
            `CHK(reg_rdata, exp_v)
        end
    end
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host_u.access(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.access(1'b0, 1'b1, a, 8'h00);
    endtask : rd
    task automatic quiet();
        host_u.release_port();
        tick();
    endtask : quiet
    // Only real BCD times go to the alarms in the random daily test
    function automatic logic [7:0] bcd(input int n);
        return 8'(((n / 10) << 4) | (n % 10));
    endfunction : bcd
    // Next word of the stimulus shift register
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    initial begin
        logic [7:0] h, m;
        repeat (5) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        // Owned places keep value bits only; unowned ones read zero
        for (int i = 0; i < 6; i++) begin
            wr(4'(8 + i), 8'hFF);
            rd(4'(8 + i), (i == 5) ? 8'h00 : (i == 1 || i == 4) ? RTCA_MASK_HOUR : 8'h7F);
        end
        quiet();
        $display("test masks done");
        cur_hour = 6'h07;
        cur_minute = 7'h45;
        wr(RTCA_ADDR_WK_MIN, 8'h45);
        wr(RTCA_ADDR_WK_HOUR, 8'h07);
        for (int n = 0; n < 8; n++) begin
            wr(RTCA_ADDR_WK_DOW, (n < 7) ? 8'(1 << n) : 8'h00);
            quiet();
            for (int d = 0; d < 8; d++) begin
                dow_counter = 3'(d);
                tick();
                `CHK({weekly_match, weekly_event}, {2{n == d && d < 7}})
            end
        end
        $display("test weekday done");
        // Noon in 12-hour mode, then midnight, then noon again
        mode_24h = 1'b0;
        cur_hour = 6'h32;
        cur_minute = 7'h00;
        wr(RTCA_ADDR_DY_MIN, 8'h00);
        wr(RTCA_ADDR_DY_HOUR, 8'h32);
        wr(RTCA_ADDR_WK_HOUR, 8'h32);
        rd(RTCA_ADDR_DY_HOUR, 8'h32);
        quiet();
        `CHK({daily_match, daily_pm, weekly_pm}, 3'b111)
        `CHK({weekly_mode_stale, daily_mode_stale}, 2'b00)
        cur_hour = 6'h12;
        tick();
        `CHK(daily_match, 1'b0)
        cur_hour = 6'h32;
        tick();
        `CHK({daily_match, daily_event}, 2'b11)
        mode_24h = 1'b1;
        tick();
        `CHK({daily_event, daily_pm, weekly_pm}, 3'b000)
        `CHK({weekly_mode_stale, daily_mode_stale}, 2'b11)
        $display("test twelve hour done");
        for (int k = 0; k < 8; k++) begin
            lfsr = lfsr_next(lfsr);
            h = bcd(int'(lfsr[7:0]) % 24);
            m = bcd(int'(lfsr[15:8]) % 60);
            wr(RTCA_ADDR_DY_HOUR, h);
            wr(RTCA_ADDR_DY_MIN, m);
            rd(RTCA_ADDR_DY_HOUR, h);
            rd(RTCA_ADDR_DY_MIN, m);
            cur_hour = h[5:0];
            cur_minute = m[6:0];
            quiet();
            `CHK(daily_match, 1'b1)
            cur_minute = m[6:0] ^ 7'h01;
            tick();
            `CHK(daily_match, 1'b0)
        end
        $display("test random daily done");
        `CHK({weekly_valid, daily_valid}, 2'b11)
        `CHK({weekly_mode_stale, daily_mode_stale}, 2'b10)
        osc_stop_flag = 1'b1;
        tick();
        osc_stop_flag = 1'b0;
        tick();
        `CHK({weekly_valid, daily_valid}, 2'b00)
        rd(RTCA_ADDR_DY_HOUR, h);
        quiet();
        $display("test osc stop done");
        complete_run();
    end
endmodule : rtca_alarm_regs_tb
